/* logic/omrcb_bank.sv */
// Purpose: Configuration bank for two optical modulators and the reference block
// Assumes: Byte register port on the system clock; write and read strobes one cycle
// Notes: Outputs are registered decodes of the stored fields
// Notes on behaviour
// - Shared mode register holds integrator, comparator and reference modes, reset zero.
// - First route bit moves first offset DAC to second modulator if polarity set.
// - Second route bit moves second offset DAC to first modulator if first polarity set.
// - First polarity bit 0 subtracts offset current; code 1 is reserved.
// - Second polarity bit 0 subtracts, 1 adds offset current.
// - Full-scale code n gives 1 uA times two to n, reset code 4.
// - Second scale code n gives (n+1)/8; codes 8 to 15 reserved.
// - First scale code 4 is 0.625, code 7 is 1.000, others reserved.
// - Per sequence amplitude bit 5 and capacitance code; above 15 reserved.
// - Per sequence reference current code; above 31 reserved.
// - Active sequence picks its own capacitance and current settings.
// - Reference bit 6 picks the low-noise LED current source, reset one.
// - Reference bit 4 picks old start-up circuit when set, reset zero.
// - Reference bit 3 enables the LED reference buffer, reset zero.
module omrcb_bank (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [omrcb_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [omrcb_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic seq2_active_i,
   output logic [omrcb_pkg::DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output omrcb_pkg::omrcb_mod_t first_modulator_o,
   output omrcb_pkg::omrcb_mod_t second_modulator_o,
   output omrcb_pkg::omrcb_shared_t shared_o
);
   import omrcb_pkg::*;
   localparam int unsigned NREG = 14;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   function automatic logic [7:0] reg_offset(input int unsigned idx);
      case (idx)
         0: reg_offset = OFS_REFERENCE_ENABLES;
         1: reg_offset = OFS_SHARED_MODES;
         2: reg_offset = OFS_FIRST_OFFSET_CTRL;
         3: reg_offset = OFS_FIRST_REF_SCALE;
         4: reg_offset = OFS_FIRST_S1_INTEGRATOR;
         5: reg_offset = OFS_FIRST_S1_REFCURRENT;
         6: reg_offset = OFS_FIRST_S2_INTEGRATOR;
         7: reg_offset = OFS_FIRST_S2_REFCURRENT;
         8: reg_offset = OFS_SECOND_OFFSET_CTRL;
         9: reg_offset = OFS_SECOND_REF_SCALE;
         10: reg_offset = OFS_SECOND_S1_INTEGRATOR;
         11: reg_offset = OFS_SECOND_S1_REFCURRENT;
         12: reg_offset = OFS_SECOND_S2_INTEGRATOR;
         default: reg_offset = OFS_SECOND_S2_REFCURRENT;
      endcase
   endfunction

   // Only defined bit positions are kept; the rest read zero
   function automatic logic [7:0] reg_mask(input int unsigned idx);
      case (idx)
         0: reg_mask = MASK_REFERENCE;
         1: reg_mask = MASK_SHARED;
         2, 8: reg_mask = MASK_OFFSET_CTRL;
         3, 9: reg_mask = MASK_REF_SCALE;
         4, 6, 10, 12: reg_mask = MASK_INTEGRATOR;
         default: reg_mask = MASK_REFCURRENT;
      endcase
   endfunction

   function automatic logic [7:0] reg_reset(input int unsigned idx);
      case (idx)
         0: reg_reset = RST_REFERENCE;
         2, 8: reg_reset = RST_OFFSET_CTRL;
         default: reg_reset = RST_ZERO;
      endcase
   endfunction

   logic [7:0] regs [NREG];
   logic [7:0] next_regs [NREG];
   logic [7:0] next_rdata;
   logic next_rvalid;
   logic [7:0] rdata_q;
   logic rvalid_q;

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         next_regs[i] = regs[i];
         if (reg_write_i && reg_addr_i == reg_offset(i)) begin
            // Reserved codes stored as written
            next_regs[i] = reg_wdata_i & reg_mask(i);
         end
      end
   end

   generate
      for (genvar g = 0; g < NREG; g++) begin : g_reg
         always_ff @(posedge clk_sys_i or posedge reset_i) begin
            if (reset_i) begin
               regs[g] <= reg_reset(g);
            end else begin
               regs[g] <= next_regs[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      next_rvalid = reg_read_i;
      if (reg_read_i) begin
         for (int i = 0; i < NREG; i++) begin
            if (reg_addr_i == reg_offset(i)) begin
               next_rdata = regs[i];
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= next_rdata;
         rvalid_q <= next_rvalid;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;

   // ----------------------------------------
   // Static decodes
   // ----------------------------------------
   logic [7:0] ctl1;
   logic [7:0] ctl2;
   logic first_offset_route;
   logic second_offset_route;
   logic first_offset_polarity;
   logic second_offset_polarity;
   logic [3:0] first_reference_scaler;
   logic [3:0] second_reference_scaler;
   omrcb_mod_t next_first;
   omrcb_mod_t next_second;
   omrcb_shared_t next_shared;
   omrcb_mod_t first_q;
   omrcb_mod_t second_q;
   omrcb_shared_t shared_q;
   logic f_amp, s_amp, f_res, s_res;
   logic [4:0] f_cap, s_cap;
   logic [7:0] f_cur, s_cur;

   assign ctl1 = regs[2];
   assign ctl2 = regs[8];
   assign first_offset_route = ctl1[POS_ROUTE];
   assign second_offset_route = ctl2[POS_ROUTE];
   assign first_offset_polarity = ctl1[POS_POLARITY];
   assign second_offset_polarity = ctl2[POS_POLARITY];
   assign first_reference_scaler = regs[3][3:0];
   assign second_reference_scaler = regs[9][3:0];

   // Per-sequence selection runs in its own registered stage
   omrcb_seq_select u_first_seq (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .seq2_active_i(seq2_active_i),
      .s1_integrator_i(regs[4]),
      .s1_current_i(regs[5]),
      .s2_integrator_i(regs[6]),
      .s2_current_i(regs[7]),
      .amplitude_o(f_amp),
      .capacitance_o(f_cap),
      .current_o(f_cur),
      .reserved_o(f_res)
   );

   omrcb_seq_select u_second_seq (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .seq2_active_i(seq2_active_i),
      .s1_integrator_i(regs[10]),
      .s1_current_i(regs[11]),
      .s2_integrator_i(regs[12]),
      .s2_current_i(regs[13]),
      .amplitude_o(s_amp),
      .capacitance_o(s_cap),
      .current_o(s_cur),
      .reserved_o(s_res)
   );

   always_comb begin
      next_first = '0;
      next_second = '0;
      next_first.on = ctl1[POS_MOD_ON];
      next_second.on = ctl2[POS_MOD_ON];
      // Routing only takes effect with first polarity set
      next_first.offset_dac_sel = (first_offset_route && first_offset_polarity)
         ? 2'b10 : 2'b01;
      next_second.offset_dac_sel = (second_offset_route && first_offset_polarity)
         ? 2'b01 : 2'b10;
      next_first.polarity = first_offset_polarity;
      next_second.polarity = second_offset_polarity;
      next_first.fullscale = ctl1[2:0];
      next_second.fullscale = ctl2[2:0];
      next_first.fullscale_onehot = 8'h01 << ctl1[2:0];
      next_second.fullscale_onehot = 8'h01 << ctl2[2:0];
      next_first.ref_scale = first_reference_scaler;
      next_second.ref_scale = second_reference_scaler;
      next_first.ref_scale_reserved = (first_reference_scaler != FIRST_SCALE_0P625)
         && (first_reference_scaler != FIRST_SCALE_1P000);
      next_second.ref_scale_reserved = second_reference_scaler > SECOND_SCALE_MAX;
      next_first.amplitude_scaling = f_amp;
      next_second.amplitude_scaling = s_amp;
      next_first.capacitance = f_cap;
      next_second.capacitance = s_cap;
      next_first.reference_current = f_cur;
      next_second.reference_current = s_cur;
      // Polarity code 1 counts as reserved on the first modulator
      next_first.code_reserved = f_res || first_offset_polarity;
      next_second.code_reserved = s_res;
      next_shared.integrator_mode = regs[1][6:5];
      next_shared.comparator_mode = regs[1][4:3];
      next_shared.refdac_mode = regs[1][2:0];
      next_shared.bandgap_on = regs[0][POS_BANDGAP_ON];
      next_shared.led_lownoise_source = regs[0][POS_LED_LOWNOISE];
      next_shared.vcm_buffer_on = regs[0][POS_VCM_BUFFER_ON];
      next_shared.startup_old = regs[0][POS_STARTUP_OLD];
      next_shared.led_reference_buffer_on = regs[0][POS_LED_REF_BUFFER_ON];
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         first_q <= '0;
         second_q <= '0;
         shared_q <= '0;
      end else begin
         first_q <= next_first;
         second_q <= next_second;
         shared_q <= next_shared;
      end
   end

   assign first_modulator_o = first_q;
   assign second_modulator_o = second_q;
   assign shared_o = shared_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   rd_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_read_i && reg_addr_i == OFS_REFERENCE_ENABLES |=> reg_rdata_o[2:0] == 3'h0)
      else $error("Undefined reference bits read nonzero");
   route_first_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 (first_modulator_o.offset_dac_sel == 2'b10) == $past(ctl1[5] && ctl1[3]))
      else $error("First offset routing wrong");
   route_second_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 (second_modulator_o.offset_dac_sel == 2'b01) == $past(ctl2[5] && ctl1[3]))
      else $error("Second offset routing wrong");
   mod_on_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_write_i && reg_addr_i == OFS_FIRST_OFFSET_CTRL |=> ##1
      first_modulator_o.on == $past(reg_wdata_i[4], 2))
      else $error("First modulator enable not applied");
   // First edge after release still shows the reset image, not the decode
   fs_decode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !reset_i ##1 1'b1 |-> second_modulator_o.fullscale_onehot == (8'h01 << $past(ctl2[2:0])))
      else $error("Full-scale decode wrong");
   scale_res_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 second_modulator_o.ref_scale_reserved == $past(regs[9][3]))
      else $error("Second scale reserved flag wrong");
   first_res_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 $past(regs[3][3:0] == 4'h7) |-> !first_modulator_o.ref_scale_reserved)
      else $error("First scale code seven flagged reserved");
   ledsrc_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !reset_i ##1 1'b1 |-> shared_o.led_lownoise_source == $past(regs[0][6]))
      else $error("LED source select wrong");
   modes_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_write_i && reg_addr_i == OFS_SHARED_MODES |=> ##1
      shared_o.refdac_mode == $past(reg_wdata_i[2:0], 2))
      else $error("Reference DAC mode not applied");
   startup_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 shared_o.startup_old == $past(regs[0][4]))
      else $error("Start-up select wrong");
   ledbuf_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ##1 shared_o.led_reference_buffer_on == $past(regs[0][3]))
      else $error("LED buffer enable wrong");
   cap_seq_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      seq2_active_i [*3] |-> ##2 first_modulator_o.capacitance == $past(regs[6][4:0], 2))
      else $error("Sequence two capacitance not used");
   cur_seq_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !seq2_active_i [*3] |-> ##2 second_modulator_o.reference_current == $past(regs[11], 2))
      else $error("Sequence one current not used");

   seq_swap_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      !seq2_active_i ##1 seq2_active_i);
   route_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      first_modulator_o.offset_dac_sel == 2'b10);
   readback_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      reg_write_i ##1 reg_read_i ##1 reg_rvalid_o);
endmodule // omrcb_bank

/* logic/omrcb_pkg.sv */
// Purpose: Constants and types for the modulator and reference configuration bank
// Assumes: 8-bit register port with byte addresses as printed
// Notes: Single-bit field positions and reset values live here; multi-bit fields are sliced in the bank
package omrcb_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_REFERENCE_ENABLES = 8'h15;
   localparam logic [7:0] OFS_SHARED_MODES = 8'h1a;
   localparam logic [7:0] OFS_FIRST_OFFSET_CTRL = 8'h1b;
   localparam logic [7:0] OFS_FIRST_REF_SCALE = 8'h1c;
   localparam logic [7:0] OFS_FIRST_S1_INTEGRATOR = 8'h1d;
   localparam logic [7:0] OFS_FIRST_S1_REFCURRENT = 8'h1e;
   localparam logic [7:0] OFS_FIRST_S2_INTEGRATOR = 8'h1f;
   localparam logic [7:0] OFS_FIRST_S2_REFCURRENT = 8'h20;
   localparam logic [7:0] OFS_SECOND_OFFSET_CTRL = 8'h21;
   localparam logic [7:0] OFS_SECOND_REF_SCALE = 8'h22;
   localparam logic [7:0] OFS_SECOND_S1_INTEGRATOR = 8'h23;
   localparam logic [7:0] OFS_SECOND_S1_REFCURRENT = 8'h24;
   localparam logic [7:0] OFS_SECOND_S2_INTEGRATOR = 8'h25;
   localparam logic [7:0] OFS_SECOND_S2_REFCURRENT = 8'h26;

   // ----------------------------------------
   // Writable bit masks and reset values
   // ----------------------------------------
   localparam logic [7:0] MASK_REFERENCE = 8'hf8;
   localparam logic [7:0] MASK_SHARED = 8'h7f;
   localparam logic [7:0] MASK_OFFSET_CTRL = 8'h3f;
   localparam logic [7:0] MASK_REF_SCALE = 8'h0f;
   localparam logic [7:0] MASK_INTEGRATOR = 8'h3f;
   localparam logic [7:0] MASK_REFCURRENT = 8'hff;
   localparam logic [7:0] RST_REFERENCE = 8'h40;
   localparam logic [7:0] RST_OFFSET_CTRL = 8'h04;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned POS_BANDGAP_ON = 7;
   localparam int unsigned POS_LED_LOWNOISE = 6;
   localparam int unsigned POS_VCM_BUFFER_ON = 5;
   localparam int unsigned POS_STARTUP_OLD = 4;
   localparam int unsigned POS_LED_REF_BUFFER_ON = 3;
   localparam int unsigned POS_ROUTE = 5;
   localparam int unsigned POS_MOD_ON = 4;
   localparam int unsigned POS_POLARITY = 3;
   localparam int unsigned POS_AMPLITUDE = 5;

   // Codes that carry a defined meaning
   localparam logic [3:0] FIRST_SCALE_0P625 = 4'h4;
   localparam logic [3:0] FIRST_SCALE_1P000 = 4'h7;
   localparam logic [3:0] SECOND_SCALE_MAX = 4'h7;
   localparam logic [4:0] CAP_CODE_MAX = 5'h0f;
   localparam logic [7:0] IREF_CODE_MAX = 8'h1f;

   typedef struct packed {
      logic on;
      logic [1:0] offset_dac_sel;   // Bit0: this DAC to first, bit1: this DAC to second
      logic polarity;
      logic [2:0] fullscale;
      logic [7:0] fullscale_onehot;  // 1 uA << code
      logic [3:0] ref_scale;
      logic ref_scale_reserved;
      logic amplitude_scaling;
      logic [4:0] capacitance;
      logic [7:0] reference_current;
      logic code_reserved;          // Active sequence holds a reserved code; first also flags polarity 1
   } omrcb_mod_t;

   typedef struct packed {
      logic [1:0] integrator_mode;
      logic [1:0] comparator_mode;
      logic [2:0] refdac_mode;
      logic bandgap_on;
      logic led_lownoise_source;
      logic vcm_buffer_on;
      logic startup_old;
      logic led_reference_buffer_on;
   } omrcb_shared_t;
endpackage

/* logic/omrcb_seq_select.sv */
// Purpose: Per-sequence setting selector for one modulator
// Assumes: Sequence select is a same-clock level from the sequencer
// Notes: Registered so the analog side never sees a decode glitch
module omrcb_seq_select (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic seq2_active_i,
   input wire logic [7:0] s1_integrator_i,
   input wire logic [7:0] s1_current_i,
   input wire logic [7:0] s2_integrator_i,
   input wire logic [7:0] s2_current_i,
   output logic amplitude_o,
   output logic [4:0] capacitance_o,
   output logic [7:0] current_o,
   output logic reserved_o
);
   import omrcb_pkg::*;
   logic [7:0] next_integ;
   logic [7:0] next_cur;
   logic amp_q;
   logic [4:0] cap_q;
   logic [7:0] cur_q;
   logic next_res;
   logic res_q;

   always_comb begin
      next_integ = seq2_active_i ? s2_integrator_i : s1_integrator_i;
      next_cur = seq2_active_i ? s2_current_i : s1_current_i;
      next_res = (next_integ[4:0] > CAP_CODE_MAX) || (next_cur > IREF_CODE_MAX);
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         amp_q <= 1'b0;
         cap_q <= 5'h00;
         cur_q <= 8'h00;
         res_q <= 1'b0;
      end else begin
         amp_q <= next_integ[POS_AMPLITUDE];
         cap_q <= next_integ[4:0];
         cur_q <= next_cur;
         res_q <= next_res;
      end
   end

   assign amplitude_o = amp_q;
   assign capacitance_o = cap_q;
   assign current_o = cur_q;
   assign reserved_o = res_q;

   seq_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      1'b1 ##1 1'b1 |-> current_o == $past(seq2_active_i ? s2_current_i : s1_current_i))
      else $error("Sequence current does not follow selected sequence");
endmodule // omrcb_seq_select

/* tb/omrcb_analog_model.sv */
// Purpose: Behavioural analog side, offset current reaching each modulator
// Assumes: Decoded controls from the bank are settled when looked at
// Notes: Currents in uA; a modulator that is off takes no offset current
module omrcb_analog_model (
   input wire omrcb_pkg::omrcb_mod_t first_modulator_i,
   input wire omrcb_pkg::omrcb_mod_t second_modulator_i,
   output logic [15:0] first_offset_ua_o,
   output logic [15:0] second_offset_ua_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import omrcb_pkg::*;
   logic [15:0] dac1_ua;
   logic [15:0] dac2_ua;
   always_comb begin
      dac1_ua = 16'h0001 << first_modulator_i.fullscale;
      dac2_ua = 16'h0001 << second_modulator_i.fullscale;
      first_offset_ua_o = 16'h0000;
      second_offset_ua_o = 16'h0000;
      // A DAC steered to both would double count, so the bench never expects it
      if (first_modulator_i.offset_dac_sel[0]) first_offset_ua_o += dac1_ua;
      if (first_modulator_i.offset_dac_sel[1]) second_offset_ua_o += dac1_ua;
      if (second_modulator_i.offset_dac_sel[0]) first_offset_ua_o += dac2_ua;
      if (second_modulator_i.offset_dac_sel[1]) second_offset_ua_o += dac2_ua;
      if (!first_modulator_i.on) first_offset_ua_o = 16'h0000;
      if (!second_modulator_i.on) second_offset_ua_o = 16'h0000;
   end
endmodule // omrcb_analog_model

/* tb/optical_modulator_ref_config_bank_test.sv */
// Purpose: Self-checking bench for the modulator and reference bank
// Assumes: One-cycle strobes; outputs settle within four edges of a write
// Notes: Table rows first, then reset and hand-written decode cases
module optical_modulator_ref_config_bank_test;
   timeunit 1ns;
   timeprecision 1ns;
   import omrcb_pkg::*;
   typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} omrcb_row_t;
   logic clk_sys_i;
   logic reset_i;
   logic [7:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic reg_write_i;
   logic reg_read_i;
   logic seq2_active_i;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   omrcb_mod_t first_modulator_o;
   omrcb_mod_t second_modulator_o;
   omrcb_shared_t shared_o;
   logic [15:0] first_offset_ua;
   logic [15:0] second_offset_ua;
   int mismatches;
   int n_checks;
   int cycles;
   // Last row is an unmapped address
   omrcb_row_t rows [15] = '{'{8'h15, 8'hff, 8'hf8}, '{8'h1a, 8'hff, 8'h7f},
      '{8'h1b, 8'hff, 8'h3f}, '{8'h1c, 8'hff, 8'h0f}, '{8'h1d, 8'hff, 8'h3f},
      '{8'h1e, 8'hff, 8'hff}, '{8'h1f, 8'hff, 8'h3f}, '{8'h20, 8'ha5, 8'ha5},
      '{8'h21, 8'hff, 8'h3f}, '{8'h22, 8'hff, 8'h0f}, '{8'h23, 8'hff, 8'h3f},
      '{8'h24, 8'h5a, 8'h5a}, '{8'h25, 8'hff, 8'h3f}, '{8'h26, 8'hff, 8'hff},
      '{8'h30, 8'hff, 8'h00}};
   logic [7:0] sc_code [4] = '{8'h04, 8'h07, 8'h05, 8'h08};
   logic sc_first [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic sc_second [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

   omrcb_bank u_omrcb_bank (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i),
      .seq2_active_i(seq2_active_i),
      .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o),
      .first_modulator_o(first_modulator_o),
      .second_modulator_o(second_modulator_o),
      .shared_o(shared_o)
   );

   omrcb_analog_model u_omrcb_analog_model (
      .first_modulator_i(first_modulator_o),
      .second_modulator_i(second_modulator_o),
      .first_offset_ua_o(first_offset_ua),
      .second_offset_ua_o(second_offset_ua)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [7:0] rst_val(input logic [7:0] a);
      return (a == 8'h15) ? 8'h40 : ((a == 8'h1b || a == 8'h21) ? 8'h04 : 8'h00);
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_write_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_read_i <= 1'b0;
      #1;
      chk({15'h0000, reg_rvalid_o}, 16'h0001);
      chk({8'h00, reg_rdata_o}, {8'h00, exp});
   endtask

   // Sequence outputs need two edges after the taking edge
   task automatic settle;
      repeat (4) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      reset_i = 1'b1;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      reg_write_i = 1'b0;
      reg_read_i = 1'b0;
      seq2_active_i = 1'b0;
      mismatches = 0;
      n_checks = 0;
      cycles = 0;
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].rdata);
      end
      // Reset in mid-run after every register was dirtied
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      foreach (rows[i]) rd(rows[i].addr, rst_val(rows[i].addr));
      settle();
      chk({4'h0, shared_o}, 16'h0008);
      chk({8'h00, second_modulator_o.fullscale_onehot}, 16'h0010);
      wr(8'h1a, 8'h6b);
      // Bandgap and common-mode buffer on before any measurement
      wr(8'h15, 8'hb8);
      settle();
      chk({4'h0, shared_o}, 16'h0d77);
      // Offset DAC steering seen from the analog side
      wr(8'h1b, 8'h3c);
      wr(8'h21, 8'h17);
      settle();
      chk(first_offset_ua, 16'h0000);
      chk(second_offset_ua, 16'h0090);
      chk({15'h0000, first_modulator_o.code_reserved}, 16'h0001);
      wr(8'h21, 8'h3f);
      settle();
      chk(first_offset_ua, 16'h0080);
      chk(second_offset_ua, 16'h0010);
      chk({14'h0000, second_modulator_o.polarity, second_modulator_o.code_reserved},
          16'h0002);
      wr(8'h1b, 8'h34);
      settle();
      chk(first_offset_ua, 16'h0010);
      chk(second_offset_ua, 16'h0080);
      chk({15'h0000, first_modulator_o.code_reserved}, 16'h0000);
      chk({8'h00, first_modulator_o.fullscale_onehot}, 16'h0010);
      for (int c = 0; c < 8; c++) begin
         wr(8'h21, {5'h00, c[2:0]});
         settle();
         chk({8'h00, second_modulator_o.fullscale_onehot}, 16'h0001 << c);
      end
      for (int i = 0; i < 4; i++) begin
         wr(8'h1c, sc_code[i]);
         wr(8'h22, sc_code[i]);
         settle();
         chk({15'h0000, first_modulator_o.ref_scale_reserved}, {15'h0000, sc_first[i]});
         chk({15'h0000, second_modulator_o.ref_scale_reserved}, {15'h0000, sc_second[i]});
      end
      // First modulator: sequence 1 at its top legal codes, sequence 2 one above
      wr(8'h1d, 8'h2f);
      wr(8'h1e, 8'h1f);
      wr(8'h1f, 8'h10);
      wr(8'h20, 8'h20);
      wr(8'h25, 8'h21);
      wr(8'h26, 8'h1f);
      settle();
      chk({2'b00, first_modulator_o.amplitude_scaling, first_modulator_o.capacitance,
           first_modulator_o.reference_current}, 16'h2f1f);
      chk({15'h0000, first_modulator_o.code_reserved}, 16'h0000);
      @(posedge clk_sys_i);
      seq2_active_i <= 1'b1;
      settle();
      chk({2'b00, first_modulator_o.amplitude_scaling, first_modulator_o.capacitance,
           first_modulator_o.reference_current}, 16'h1020);
      chk({15'h0000, first_modulator_o.code_reserved}, 16'h0001);
      chk({2'b00, second_modulator_o.amplitude_scaling, second_modulator_o.capacitance,
           second_modulator_o.reference_current}, 16'h211f);
      chk({15'h0000, second_modulator_o.code_reserved}, 16'h0000);
      // Standby: bandgap and common-mode buffer off again
      wr(8'h15, 8'h58);
      settle();
      chk({4'h0, shared_o}, 16'h0d6b);
      give_verdict();
   end
endmodule // optical_modulator_ref_config_bank_test
